/* verilog/phy_mgmt_regs.sv */
// What this block does
// - layer type field always reads the fixed code 0x2.
// - operational state uses codes 0,1,2 and 7..A for low-power one to four.
// - previous-state field holds the state that preceded the current one.
// - retraining arc selection supports only arc one, reading zero.
// - arc two-to-four support bit and worst-case retrain time read zero.
// - frame CRC encoding enable resets to one.
// - all lane asymmetry status, enable and support fields read zero.
// - reversal support fields hold only 0..2; asymmetric-reversal bits read zero.
// - low-power-one exit latency taken from link capability L1 exit latency.
// - low-power-four exit latency taken from link capability L0s exit latency.
// - up-state low-power latency and support fields read zero.
// - extended status bit 0 is read-only extended-feature enabled flag.
// - extended status 2:1 give extended training result, none reserved.
// - extended status 5:3 give transfer generation one to five.
// - extended status 9:6 give actual transfer rate code.
// - extended control 2:0 choose third-generation rate, default 8.0.
// - extended control 5:3 choose fourth-generation rate, default 16.0.
// - extended control bit 6 enables fourth-generation local precoding.
// - extended control 8:7 govern remote precoding request, default hardware.
// - extended capability is read-only with bits 0,1,4,5,8 only.
// - partner capability holds remap bits at local positions, rest zero.
// - training states map disabled, L0, recovery, L1..L0s onto operational states.
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_consts.svh"
module phy_mgmt_regs
   import phy_mgmt_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter logic [31:0] EXT_CAP_VALUE = 32'h0000_0133,
   parameter logic [1:0] LOCAL_REVERSAL = 2'h1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [ADDR_W-1:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // link core status
   input wire logic [2:0] train_state_i,
   input wire logic [31:0] link_cap_i,
   input wire logic ext_enabled_i,
   input wire logic [1:0] ext_train_i,
   input wire logic [2:0] ext_gen_i,
   input wire logic [3:0] ext_rate_i,
   // control toward the link core
   output logic [3:0] op_state_o,
   output logic [3:0] prev_state_o,
   output logic crc_enable_o,
   output logic [2:0] gen3_rate_sel_o,
   output logic [2:0] gen4_rate_sel_o,
   output logic gen4_precode_en_o,
   output logic [1:0] remote_precode_req_o
);
   // legal selector codes are 0..2 for every 3-bit or 2-bit selector
   function automatic logic sel_legal(input logic [2:0] code);
      sel_legal = (code <= `EXT_CTRL_FIELD_MAX);
   endfunction : sel_legal

   logic [3:0] state_ff;
   logic [3:0] prev_ff;
   logic [3:0] nxt_state;
   logic crc_en_ff;
   logic [31:0] ext_ctrl_ff;
   logic [31:0] nxt_ext_ctrl;
   logic [1:0] partner_rev_ff;
   logic [31:0] partner_ext_ff;
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic hresp_ff;
   logic [31:0] rd_value;
   logic take;
   logic [1:0] local_rev;

   assign take = hsel_i & htrans_i[1] & hready_i;
   // a strap of 3 is illegal, fall back to no reversal
   assign local_rev = (LOCAL_REVERSAL > `REVERSAL_MAX) ? 2'h0 : LOCAL_REVERSAL;

   // training state to operational state; unused states hold the last code
   always_comb begin
      nxt_state = state_ff;
      unique case (train_state_e'(train_state_i))
         TR_DISABLED: nxt_state = ST_DOWN;
         TR_L0: nxt_state = ST_UP;
         TR_RECOVERY: nxt_state = ST_DOWN_RETRAIN;
         TR_L1: nxt_state = ST_LOW_POWER_ONE;
         TR_L2: nxt_state = ST_LOW_POWER_TWO;
         TR_L3: nxt_state = ST_LOW_POWER_THREE;
         TR_L0S: nxt_state = ST_LOW_POWER_FOUR;
         TR_OTHER: nxt_state = state_ff;
      endcase
   end

   // current and previous state move together
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= 4'h0;
         prev_ff <= 4'h0;
      end else if (nxt_state != state_ff) begin
         state_ff <= nxt_state;
         prev_ff <= state_ff;
      end
   end

   // ahb address phase capture; reads get one wait so a write just before is seen
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= '0;
      end else begin
         wr_pend_ff <= take & hwrite_i;
         rd_pend_ff <= take & ~hwrite_i;
         if (take) begin
            addr_ff <= haddr_i;
         end
      end
   end

   // extended control write: reserved selector codes leave the field alone
   always_comb begin
      nxt_ext_ctrl = ext_ctrl_ff;
      if (sel_legal(hwdata_i[2:0])) begin
         nxt_ext_ctrl[2:0] = hwdata_i[2:0];
      end
      if (sel_legal(hwdata_i[5:3])) begin
         nxt_ext_ctrl[5:3] = hwdata_i[5:3];
      end
      nxt_ext_ctrl[6] = hwdata_i[6];
      if (sel_legal({1'b0, hwdata_i[8:7]})) begin
         nxt_ext_ctrl[8:7] = hwdata_i[8:7];
      end
      // reserved upper bits store and read back, no output looks at them
      nxt_ext_ctrl[31:9] = hwdata_i[31:9];
   end

   // writable registers, committed in the data phase
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         crc_en_ff <= `CRC_ENABLE_RESET;
         ext_ctrl_ff <= `EXT_CTRL_RESET;
         partner_rev_ff <= 2'h0;
         partner_ext_ff <= 32'h0000_0000;
      end else if (wr_pend_ff) begin
         unique case (addr_ff)
            `OFS_CONTROL: crc_en_ff <= hwdata_i[0];
            `OFS_EXT_CONTROL: ext_ctrl_ff <= nxt_ext_ctrl;
            `OFS_PARTNER_LANE: begin
               if (hwdata_i[1:0] <= `REVERSAL_MAX) begin
                  partner_rev_ff <= hwdata_i[1:0];
               end
            end
            `OFS_PARTNER_EXT_CAP: partner_ext_ff <= hwdata_i & `PARTNER_EXT_MASK;
            default: ;
         endcase
      end
   end

   // read mux; fixed zero fields are spelt out so they cannot drift
   always_comb begin
      rd_value = 32'h0000_0000;
      unique case (addr_ff)
         `OFS_STATE: rd_value = {16'h0000, prev_ff, state_ff, 4'h0, `LAYER_TYPE_VALUE};
         // bits 3:1 retrain arc, bit 4 asymmetry enable, both fixed zero
         `OFS_CONTROL: rd_value = {27'h0, 1'b0, 3'h0, crc_en_ff};
         // bit0 arc 2-4, 15:8 retrain time, 17:16 reversal, 18/19 asym, 20/21 up-lp
         `OFS_CAPABILITY: rd_value = {10'h0, 2'h0, 2'h0, local_rev, 8'h00, 7'h0, 1'b0};
         `OFS_PARTNER_LANE: rd_value = {30'h0, partner_rev_ff};
         `OFS_LP_TIMING: rd_value = {26'h0, link_cap_i[`L0S_EXIT_LSB +: 3],
                                     link_cap_i[`L1_EXIT_LSB +: 3]};
         `OFS_EXT_STATUS: rd_value = {22'h0, ext_rate_i, ext_gen_i, ext_train_i,
                                      ext_enabled_i};
         `OFS_EXT_CONTROL: rd_value = ext_ctrl_ff;
         `OFS_EXT_CAP: rd_value = EXT_CAP_VALUE & `EXT_CAP_MASK;
         `OFS_PARTNER_EXT_CAP: rd_value = partner_ext_ff;
         default: rd_value = 32'h0000_0000;
      endcase
   end

   // read data and wait state; response is always okay
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hrdata_ff <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end else begin
         hresp_ff <= 1'b0;
         hreadyout_ff <= ~(take & ~hwrite_i);
         if (rd_pend_ff) begin
            hrdata_ff <= rd_value;
         end
      end
   end

   // every output straight from a flip-flop
   assign hrdata_o = hrdata_ff;
   assign hreadyout_o = hreadyout_ff;
   assign hresp_o = hresp_ff;
   assign op_state_o = state_ff;
   assign prev_state_o = prev_ff;
   assign crc_enable_o = crc_en_ff;
   assign gen3_rate_sel_o = ext_ctrl_ff[2:0];
   assign gen4_rate_sel_o = ext_ctrl_ff[5:3];
   assign gen4_precode_en_o = ext_ctrl_ff[6];
   assign remote_precode_req_o = ext_ctrl_ff[8:7];

   // checks
   sequence s_read_addr;
      take && !hwrite_i;
   endsequence
   sequence s_read_done;
      !hreadyout_o ##1 hreadyout_o;
   endsequence

   a_state_prev_shift: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (nxt_state != state_ff) |=> (prev_state_o == $past(state_ff) && op_state_o == $past(nxt_state)))
      else $error("previous state did not take old state");
   a_state_map_l0s: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_L0S) |=> (op_state_o == 4'ha))
      else $error("l0s not mapped to low power four");
   a_state_map_up: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_L0) |=> (op_state_o == 4'h1))
      else $error("l0 not mapped to up");
   a_read_wait_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_read_addr |=> s_read_done)
      else $error("read did not answer after one wait");
   a_type_read_back: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_STATE)) |=> ##1 (hrdata_o[3:0] == 4'h2))
      else $error("layer type code wrong");
   a_ctrl_zero_fields: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_CONTROL)) |=> ##1 (hrdata_o[31:1] == 31'h0))
      else $error("retrain arc or asymmetry bits not zero");
   a_rsvd_code_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && addr_ff == `OFS_EXT_CONTROL && hwdata_i[2:0] > 3'h2)
      |=> $stable(gen3_rate_sel_o))
      else $error("reserved rate code was stored");
   a_sel_in_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
      gen4_rate_sel_o <= 3'h2 && gen3_rate_sel_o <= 3'h2 && remote_precode_req_o != 2'h3)
      else $error("selector holds a reserved code");
   a_ext_status_rsvd: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_EXT_STATUS)) |=> ##1 (hrdata_o[31:10] == 22'h0))
      else $error("extended status reserved bits not zero");
   a_partner_mask: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (partner_ext_ff & ~`PARTNER_EXT_MASK) == 32'h0)
      else $error("partner capability reserved bit set");
   a_partner_rev: assert property (@(posedge core_clk_i) disable iff (rst_i)
      partner_rev_ff != 2'h3)
      else $error("partner reversal support out of range");
   a_resp_okay: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !hresp_o)
      else $error("error response driven");

   // each used training code lands on its own operational state
   a_map_down: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_DISABLED) |=> (op_state_o == 4'h0))
      else $error("disabled not mapped to down");
   a_map_retrain: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_RECOVERY) |=> (op_state_o == 4'h2))
      else $error("recovery not mapped to down retrain");
   a_map_low_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_L1) |=> (op_state_o == 4'h7))
      else $error("l1 not mapped to low power one");
   a_map_low_two: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_L2) |=> (op_state_o == 4'h8))
      else $error("l2 not mapped to low power two");
   a_map_low_three: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_L3) |=> (op_state_o == 4'h9))
      else $error("l3 not mapped to low power three");
   // an unused training code must not disturb the reported state
   a_hold_on_other: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (train_state_i == TR_OTHER) |=> $stable(op_state_o))
      else $error("unused training state changed the state");
   a_state_code_legal: assert property (@(posedge core_clk_i) disable iff (rst_i)
      op_state_o inside {4'h0, 4'h1, 4'h2, [4'h7:4'ha]})
      else $error("current state holds a reserved code");
   a_prev_code_legal: assert property (@(posedge core_clk_i) disable iff (rst_i)
      prev_state_o inside {4'h0, 4'h1, 4'h2, [4'h7:4'ha]})
      else $error("previous state holds a reserved code");

   // no disable here: this one looks at what reset leaves behind
   a_reset_defaults: assert property (@(posedge core_clk_i)
      rst_i |=> (crc_enable_o && gen3_rate_sel_o == 3'h0 && gen4_rate_sel_o == 3'h0
                 && !gen4_precode_en_o && remote_precode_req_o == 2'h0 && op_state_o == 4'h0))
      else $error("reset values wrong");

   // writes land at the edge that closes the data phase
   a_ctrl_write_lands: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && addr_ff == `OFS_CONTROL)
      |=> ({31'h0, crc_enable_o} == ($past(hwdata_i) & 32'h0000_0001)))
      else $error("crc enable write lost");
   a_precode_lands: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && addr_ff == `OFS_EXT_CONTROL)
      |=> ({25'h0, gen4_precode_en_o, 6'h0} == ($past(hwdata_i) & 32'h0000_0040)))
      else $error("precoding enable write lost");
   a_gen3_lands: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && addr_ff == `OFS_EXT_CONTROL && hwdata_i[2:0] <= 3'h2)
      |=> ({29'h0, gen3_rate_sel_o} == ($past(hwdata_i) & 32'h0000_0007)))
      else $error("legal third generation code not stored");
   a_gen4_code_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && addr_ff == `OFS_EXT_CONTROL && hwdata_i[5:3] > 3'h2)
      |=> $stable(gen4_rate_sel_o))
      else $error("reserved fourth generation code was stored");
   a_req_code_held: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_pend_ff && addr_ff == `OFS_EXT_CONTROL && hwdata_i[8:7] == 2'h3)
      |=> $stable(remote_precode_req_o))
      else $error("reserved precoding request was stored");

   // read data seen at the edge that closes the data phase, one after the wait state ends
   a_cap_fixed_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_CAPABILITY))
      |=> ##1 (hrdata_o[15:0] == 16'h0000 && hrdata_o[31:18] == 14'h0))
      else $error("fixed zero capability field set");
   a_cap_reversal: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_CAPABILITY)) |=> ##1 (hrdata_o[17:16] <= 2'h2))
      else $error("local reversal support out of range");
   a_lane_partner_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_PARTNER_LANE)) |=> ##1 (hrdata_o[31:2] == 30'h0))
      else $error("partner asymmetry bits not zero");
   a_ext_cap_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_EXT_CAP))
      |=> ##1 ((hrdata_o & ~`EXT_CAP_MASK) == 32'h0))
      else $error("extended capability reserved bit set");
   a_lp_timing_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_LP_TIMING)) |=> ##1 (hrdata_o[31:6] == 26'h0))
      else $error("low power timing upper bits not zero");
   a_state_read_back: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_STATE))
      |=> ##1 (hrdata_o[15:8] == {$past(prev_state_o), $past(op_state_o)}))
      else $error("state register read wrong");
   a_ext_ctrl_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_EXT_CONTROL))
      |=> ##1 (hrdata_o[8:0] == {$past(remote_precode_req_o), $past(gen4_precode_en_o),
                                 $past(gen4_rate_sel_o), $past(gen3_rate_sel_o)}))
      else $error("extended control read differs from outputs");
   a_ext_status_raw: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (s_read_addr and (haddr_i == `OFS_EXT_STATUS))
      |=> ##1 (hrdata_o[9:0] == {$past(ext_rate_i), $past(ext_gen_i), $past(ext_train_i),
                                 $past(ext_enabled_i)}))
      else $error("extended status not shown raw");

   // bus timing: writes never wait, read data stands between reads
   a_write_no_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (take && hwrite_i) |=> hreadyout_o)
      else $error("write inserted a wait state");
   a_rdata_stands: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !rd_pend_ff |=> $stable(hrdata_o))
      else $error("read data changed without a read");
endmodule : phy_mgmt_regs
`default_nettype wire

/* verilog/phy_mgmt_consts.svh */
`ifndef PHY_MGMT_CONSTS_SVH
`define PHY_MGMT_CONSTS_SVH
// register byte offsets
`define OFS_STATE 8'h00
`define OFS_CONTROL 8'h04
`define OFS_CAPABILITY 8'h08
`define OFS_PARTNER_LANE 8'h0c
`define OFS_LP_TIMING 8'h10
`define OFS_EXT_STATUS 8'h20
`define OFS_EXT_CONTROL 8'h24
`define OFS_EXT_CAP 8'h28
`define OFS_PARTNER_EXT_CAP 8'h2c
// fixed codes
`define LAYER_TYPE_VALUE 4'h2
`define REVERSAL_MAX 2'h2
// extended control fields and resets
`define EXT_CTRL_RESET 32'h0000_0000
`define EXT_CTRL_FIELD_MAX 3'h2
`define EXT_STAT_USED_MASK 32'h0000_03ff
`define PARTNER_EXT_MASK 32'h0000_0033
`define EXT_CAP_MASK 32'h0000_0133
`define CRC_ENABLE_RESET 1'b1
// link capability field positions
`define L0S_EXIT_LSB 12
`define L1_EXIT_LSB 15
`endif

/* verilog/phy_mgmt_pkg.sv */
package phy_mgmt_pkg;
   // operational state codes of the layer
   typedef enum logic [3:0] {
      ST_DOWN = 4'h0,
      ST_UP = 4'h1,
      ST_DOWN_RETRAIN = 4'h2,
      ST_LOW_POWER_ONE = 4'h7,
      ST_LOW_POWER_TWO = 4'h8,
      ST_LOW_POWER_THREE = 4'h9,
      ST_LOW_POWER_FOUR = 4'ha
   } op_state_e;
   // training state as reported by the link core
   typedef enum logic [2:0] {
      TR_DISABLED = 3'h0,
      TR_L0 = 3'h1,
      TR_RECOVERY = 3'h3,
      TR_L1 = 3'h2,
      TR_L2 = 3'h6,
      TR_L3 = 3'h7,
      TR_L0S = 3'h5,
      TR_OTHER = 3'h4
   } train_state_e;
endpackage : phy_mgmt_pkg

/* tb/link_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stand-in for the link core: training state and raw status levels
module link_core_model
   import phy_mgmt_pkg::*;
(
   // clock
   input wire logic clk_i,
   // status toward the register block
   output logic [2:0] train_state_o,
   output logic [31:0] link_cap_o,
   output logic ext_enabled_o,
   output logic [1:0] ext_train_o,
   output logic [2:0] ext_gen_o,
   output logic [3:0] ext_rate_o
);
   // starts disabled, only codes a training machine emits
   initial begin
      train_state_o = TR_DISABLED;
      link_cap_o = 32'h0;
      {ext_rate_o, ext_gen_o, ext_train_o, ext_enabled_o} = 10'h0;
   end
   // levels move just after an edge, as the real core would
   task automatic set_train(input train_state_e t);
      @(posedge clk_i);
      train_state_o <= t;
   endtask : set_train
   // status packed rate, gen, training result, enabled
   task automatic set_status(input logic [31:0] cap, input logic [9:0] st);
      @(posedge clk_i);
      link_cap_o <= cap;
      {ext_rate_o, ext_gen_o, ext_train_o, ext_enabled_o} <= st;
   endtask : set_status
endmodule : link_core_model
`default_nettype wire

/* tb/tb_serial_phy_mgmt_status_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_consts.svh"
module tb_serial_phy_mgmt_status_control;
   import phy_mgmt_pkg::*;
   logic clk, rst, hsel, hwrite, hready, hresp, crc, pre, een;
   logic [1:0] htrans, req, etr;
   logic [7:0] haddr;
   logic [31:0] hwdata, hrdata, q, v, lcap;
   logic [3:0] op, prev, rate;
   logic [2:0] tr, g3, g4, gen;
   int n_mismatch = 0;
   int tests_run = 0;
   train_state_e trs [8] = '{TR_L0, TR_RECOVERY, TR_L1, TR_L2, TR_L3, TR_L0S, TR_OTHER,
      TR_DISABLED};
   // expected {previous, current} after each training step
   logic [7:0] se [8] = '{8'h01, 8'h12, 8'h27, 8'h78, 8'h89, 8'h9a, 8'h9a, 8'ha0};

   phy_mgmt_regs uut (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .train_state_i(tr), .link_cap_i(lcap), .ext_enabled_i(een), .ext_train_i(etr),
      .ext_gen_i(gen), .ext_rate_i(rate), .op_state_o(op), .prev_state_o(prev),
      .crc_enable_o(crc), .gen3_rate_sel_o(g3), .gen4_rate_sel_o(g4),
      .gen4_precode_en_o(pre), .remote_precode_req_o(req));
   link_core_model core (.clk_i(clk), .train_state_o(tr), .link_cap_o(lcap),
      .ext_enabled_o(een), .ext_train_o(etr), .ext_gen_o(gen), .ext_rate_o(rate));

   // 125 mhz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // case inequality so an unknown never passes
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) n_mismatch++;
   endtask : wait_rdy

   // one single word transfer; read data taken at the closing edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(q, exp);
      // response must stay okay on every read
      chk({31'h0, hresp}, 32'h0);
   endtask : rd

   // main sequence
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 8'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`OFS_STATE, 32'h2);
      rd(`OFS_CONTROL, 32'h1);
      xfer(1'b1, `OFS_CONTROL, 32'hffff_ffff);
      rd(`OFS_CONTROL, 32'h1);
      xfer(1'b1, `OFS_CONTROL, 32'h0);
      @(posedge clk);
      chk({31'h0, crc}, 32'h0);
      rd(`OFS_CAPABILITY, 32'h0001_0000);
      xfer(1'b1, `OFS_CAPABILITY, 32'hffff_ffff);
      rd(`OFS_CAPABILITY, 32'h0001_0000);
      xfer(1'b1, `OFS_PARTNER_LANE, 32'h2);
      xfer(1'b1, `OFS_PARTNER_LANE, 32'h3);
      rd(`OFS_PARTNER_LANE, 32'h2);
      xfer(1'b1, `OFS_PARTNER_LANE, 32'hffff_fff1);
      rd(`OFS_PARTNER_LANE, 32'h1);
      core.set_status(32'h0002_b000, 10'h1a5);
      rd(`OFS_LP_TIMING, 32'h1d);
      rd(`OFS_EXT_STATUS, 32'h1a5);
      core.set_status(32'h0, 10'h0c2);
      rd(`OFS_EXT_STATUS, 32'hc2);
      xfer(1'b1, `OFS_EXT_STATUS, 32'hffff_ffff);
      rd(`OFS_EXT_STATUS, 32'hc2);
      rd(`OFS_EXT_CONTROL, 32'h0);
      // every legal code; gen4 code never below gen3
      for (int i = 0; i < 3; i++) begin
         v = 32'hfedc_ba00 | (32'(i) << 7) | (32'(i % 2) << 6) | (32'(i) << 3) | 32'(i);
         xfer(1'b1, `OFS_EXT_CONTROL, v);
         rd(`OFS_EXT_CONTROL, v);
         chk(32'({req, pre, g4, g3}), v & 32'h1ff);
      end
      // reserved codes leave their fields alone, bit 6 still applies
      xfer(1'b1, `OFS_EXT_CONTROL, 32'h1db);
      rd(`OFS_EXT_CONTROL, 32'h152);
      rd(`OFS_EXT_CAP, 32'h133);
      xfer(1'b1, `OFS_EXT_CAP, 32'h0);
      rd(`OFS_EXT_CAP, 32'h133);
      xfer(1'b1, `OFS_PARTNER_EXT_CAP, 32'hffff_ffff);
      rd(`OFS_PARTNER_EXT_CAP, 32'h33);
      xfer(1'b1, 8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0);
      // walk the training states, one mapping each
      for (int i = 0; i < 8; i++) begin
         core.set_train(trs[i]);
         repeat (2) @(posedge clk);
         chk(32'({prev, op}), 32'(se[i]));
      end
      rd(`OFS_STATE, 32'h0000_a002);
      xfer(1'b1, `OFS_STATE, 32'hffff_ffff);
      rd(`OFS_STATE, 32'h0000_a002);
      // reset in mid-run restores the defaults
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`OFS_CONTROL, 32'h1);
      rd(`OFS_EXT_CONTROL, 32'h0);
      report_and_stop();
   end

   // watchdog: the run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb_serial_phy_mgmt_status_control
`default_nettype wire
